// File: design/sdadc_ctrl.sv
// Purpose: Register front end and sequencing of the sigma-delta converter.
// Assumes: Avalon-MM slave with waitrequest; modulator bit synchronous.
// Notes:   Every access takes exactly one wait cycle.
//
// The address map and the Avalon-MM slave port were decided locally.
module sdadc_ctrl
	import sdadc_pkg::*;
(
	// Clock and reset.
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// Avalon-MM register slave.
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	// Interrupt.
	output logic             conversion_irq,
	// Modulator bit stream and analog controls.
	input  wire logic        mod_bit,
	output logic             modulator_sample,
	output logic             modulator_enable,
	output logic             auto_zero_ctl,
	output logic [1:0]       input_gain_select,
	output logic             chopper_polarity
);

	////////////////////////////////////////////////////////////////////////////
	// State declarations.

	logic [11:0]        ctrl_r;
	logic [11:0]        ctrl_nxt;
	logic [1:0]         mask_r;
	logic [1:0]         mask_nxt;
	logic [1:0]         status_r;
	logic [1:0]         status_nxt;
	logic signed [14:0] hold_r;
	logic [1:0]         settle_r;
	logic [1:0]         settle_nxt;
	logic               wait_r;
	logic [31:0]        rdata_r;
	logic [31:0]        rdata_nxt;
	logic               irq_r;
	logic [9:0]         chop_cnt_r;
	logic [9:0]         chop_cnt_nxt;
	logic               chop_r;
	logic               chop_nxt;
	logic               mod_en_r;
	logic               az_r;
	logic [1:0]         gain_r;

	////////////////////////////////////////////////////////////////////////////
	// Field views of the control register.

	logic               mod_en_w;
	logic               filt_en_w;
	logic               az_w;
	logic               clksel_w;
	logic [2:0]         dec_w;
	logic [1:0]         gain_w;
	logic [1:0]         chop_w;

	assign mod_en_w  = ctrl_r[SDADC_CTL_MOD_EN];
	assign filt_en_w = ctrl_r[SDADC_CTL_FILT_EN];
	assign az_w      = ctrl_r[SDADC_CTL_AZ];
	assign clksel_w  = ctrl_r[SDADC_CTL_CLKSEL];
	assign dec_w     = ctrl_r[SDADC_CTL_DEC_LO +: 3];
	assign gain_w    = ctrl_r[SDADC_CTL_GAIN_LO +: 2];
	assign chop_w    = ctrl_r[SDADC_CTL_CHOP_LO +: 2];

	////////////////////////////////////////////////////////////////////////////
	// Bus decode.

	logic       req_w;
	logic       acc_w;
	logic       wr_w;
	logic       rd_w;
	logic       sel_ctrl_w;
	logic       sel_result_w;
	logic       sel_status_w;
	logic       sel_mask_w;
	logic [31:0] wmask_w;

	// The first cycle of a request sees the wait high; the second completes it.
	// A fixed single wait keeps read data registered without a mux on the bus.
	assign req_w        = avs_read || avs_write;
	assign acc_w        = req_w && !wait_r;
	assign wr_w         = acc_w && avs_write;
	assign rd_w         = acc_w && avs_read;
	assign sel_ctrl_w   = (avs_address == SDADC_OFS_CTRL);
	assign sel_result_w = (avs_address == SDADC_OFS_RESULT);
	assign sel_status_w = (avs_address == SDADC_OFS_STATUS);
	assign sel_mask_w   = (avs_address == SDADC_OFS_MASK);
	assign wmask_w      = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
	                       {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

	////////////////////////////////////////////////////////////////////////////
	// Control and mask registers.

	logic [31:0] ctrl_wide_w;
	logic [31:0] mask_wide_w;

	// Byte enables merge new bits with old; bits above the field are dropped.
	assign ctrl_wide_w = (avs_writedata & wmask_w) | ({20'h00000, ctrl_r} & ~wmask_w);
	assign mask_wide_w = (avs_writedata & wmask_w) | ({30'h0, mask_r} & ~wmask_w);
	assign ctrl_nxt    = (wr_w && sel_ctrl_w) ? ctrl_wide_w[11:0] : ctrl_r;
	assign mask_nxt    = (wr_w && sel_mask_w) ? mask_wide_w[1:0] : mask_r;

	////////////////////////////////////////////////////////////////////////////
	// Restart and settling.

	logic        run_w;
	logic        restart_w;
	logic        switch_w;
	logic        filt_clr_w;
	logic        res_stb_w;
	logic signed [14:0] res_w;
	logic        settled_w;

	// Both enables are needed before samples are filtered; the modulator enable alone takes them.
	assign run_w     = mod_en_w && filt_en_w; // RQ18
	// Clearing auto-zero, or any stopped state, flushes the comb filter.
	assign restart_w = az_r && !az_w; // RQ10
	assign filt_clr_w = !run_w || restart_w;
	// Any change of gain, auto-zero or rate means the next results are unsettled.
	assign switch_w  = (gain_w != gain_r) || (az_w != az_r) || filt_clr_w ||
	                   (wr_w && sel_ctrl_w && (ctrl_wide_w[7:3] != ctrl_r[7:3]));
	assign settled_w = (settle_r == SDADC_SETTLE_RESULTS);
	// Count results after a switch; the third and later ones are settled.
	assign settle_nxt = switch_w ? 2'd0 :
	                    (res_stb_w && !settled_w) ? settle_r + 2'd1 : settle_r; // RQ7

	////////////////////////////////////////////////////////////////////////////
	// Status and interrupt.

	logic [1:0] ev_w;
	logic [1:0] clr_w;

	// A result sets the sticky flag; it reads as settled when past the first two.
	assign ev_w       = {res_stb_w && settled_w, res_stb_w}; // RQ4 RQ7
	// A read of status clears it, but an event in that same cycle survives.
	assign clr_w      = (rd_w && sel_status_w) ? 2'b11 : 2'b00;
	assign status_nxt = (status_r & ~clr_w) | ev_w; // RQ19

	////////////////////////////////////////////////////////////////////////////
	// Read data.

	logic [31:0] res_word_w;

	// Result sign extends into bit 15 and above so both top bits show the sign.
	assign res_word_w = {{17{hold_r[14]}}, hold_r}; // RQ3
	assign rdata_nxt  = sel_ctrl_w   ? {20'h00000, ctrl_r} :
	                    sel_result_w ? res_word_w :
	                    sel_status_w ? {30'h0, status_r} :
	                    sel_mask_w   ? {30'h0, mask_r} : 32'h00000000;

	////////////////////////////////////////////////////////////////////////////
	// Chopper phase.

	logic [9:0] chop_half_w;
	logic       chop_auto_w;
	logic       chop_flip_w;

	// Codes 10 and 11 alternate the polarity; 00 and 01 hold it fixed.
	assign chop_auto_w  = chop_w[1];
	assign chop_half_w  = chop_w[0] ? SDADC_CHOP_HALF_SLOW : SDADC_CHOP_HALF_FAST;
	assign chop_flip_w  = chop_auto_w && (chop_cnt_r >= chop_half_w - 10'd1);
	assign chop_cnt_nxt = (!chop_auto_w || chop_flip_w) ? 10'd0 : chop_cnt_r + 10'd1;
	assign chop_nxt     = chop_auto_w ? (chop_r ^ chop_flip_w) : // RQ13
	                      (chop_w == SDADC_CHOP_NEG);

	////////////////////////////////////////////////////////////////////////////
	// Bus handshake and read data registers.

	// Wait stays high when idle and drops for the completing cycle only.
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			wait_r  <= 1'b1;
			rdata_r <= 32'h00000000;
		end
		else
		begin
			wait_r  <= !(req_w && wait_r);
			rdata_r <= (req_w && wait_r) ? rdata_nxt : rdata_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Software registers, result holding and flags.

	// The held result changes only when a new one arrives.
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			ctrl_r   <= SDADC_CTRL_RST;
			mask_r   <= SDADC_MASK_RST;
			status_r <= 2'b00;
			hold_r   <= 15'sd0;
			settle_r <= 2'd0;
			irq_r    <= 1'b0;
		end
		else
		begin
			ctrl_r   <= ctrl_nxt;
			mask_r   <= mask_nxt;
			status_r <= status_nxt;
			hold_r   <= res_stb_w ? res_w : hold_r;
			settle_r <= settle_nxt;
			irq_r    <= |(status_nxt & mask_nxt); // RQ19
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Analog-facing controls.

	// Auto-zero shorts the inputs; gain select passes straight to the front end.
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			mod_en_r   <= 1'b0;
			az_r       <= 1'b0;
			gain_r     <= 2'b00;
			chop_cnt_r <= 10'd0;
			chop_r     <= 1'b0;
		end
		else
		begin
			mod_en_r   <= mod_en_w;
			az_r       <= az_w; // RQ9
			gain_r     <= gain_w; // RQ12 RQ17
			chop_cnt_r <= chop_cnt_nxt;
			chop_r     <= chop_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sample clock and comb filter.

	logic samp_w;

	// The sample clock runs with the modulator enable alone.
	sdadc_sample_clk u_clk (
		.clk_sys      (clk_sys),
		.rst          (rst),
		.run          (mod_en_w),
		.slow_sel     (clksel_w), // RQ16
		.sample_stb_r (samp_w)
	);

	// The filter only counts samples while both enables are set.
	sdadc_comb u_comb (
		.clk_sys      (clk_sys),
		.rst          (rst),
		.clr          (filt_clr_w),
		.dec_sel      (dec_w), // RQ5
		.sample_stb   (samp_w && run_w),
		.mod_bit      (mod_bit),
		.result_r     (res_w),
		.result_stb_r (res_stb_w)
	);

	////////////////////////////////////////////////////////////////////////////
	// Outputs.

	assign avs_readdata      = rdata_r;
	assign avs_waitrequest   = wait_r;
	assign conversion_irq    = irq_r;
	assign modulator_sample  = samp_w;
	assign modulator_enable  = mod_en_r;
	assign auto_zero_ctl     = az_r;
	assign input_gain_select = gain_r;
	assign chopper_polarity  = chop_r;
endmodule

// File: pkg/sdadc_pkg.sv
// Purpose: Shared constants for the sigma-delta converter output control.
// Assumes: Main clock of 100 MHz; registers are 32-bit aligned words.
// Notes:   Overview list below names the behaviour each tag marks.
// Overview of operation
// RQ1: Full scale output is 15625 codes.
// RQ2: Results clamp at plus or minus 15625.
// RQ3: Fifteen-bit two's complement, bit 14 is sign.
// RQ4: One result every N samples raises interrupt.
// RQ5: Decimation field picks N; select bit rate.
// RQ6: Each result spans last 2N modulator samples.
// RQ7: First two results after switching are unsettled.
// RQ8: Software drops first two interrupts after switching.
// RQ9: Auto-zero shorts the converter inputs together.
// RQ10: Clearing auto-zero restarts the converter.
// RQ11: Software subtracts the stored offset code.
// RQ12: Two-bit field selects converter input gain.
// RQ13: Chopper 00 positive, 01 negative, toggling chops.
// RQ14: Software keeps chopping between 1 and 2 kHz.
// RQ15: Output rate divides sample rate by 125..8000.
// RQ16: Sample rate is main clock over 25 or 50.
// RQ17: Gain codes give 2/3, 1, 2, 7/3.
// RQ18: Modulator and filter enables both start conversion.
// RQ19: Interrupt flag sticks until cleared, gated by enable.
package sdadc_pkg;
	// Register byte offsets.
	localparam logic [3:0] SDADC_OFS_CTRL   = 4'h0;
	localparam logic [3:0] SDADC_OFS_RESULT = 4'h4;
	localparam logic [3:0] SDADC_OFS_STATUS = 4'h8;
	localparam logic [3:0] SDADC_OFS_MASK   = 4'hc;
	// Control field positions.
	localparam int SDADC_CTL_MOD_EN  = 0;
	localparam int SDADC_CTL_FILT_EN = 1;
	localparam int SDADC_CTL_AZ      = 2;
	localparam int SDADC_CTL_CLKSEL  = 3;
	localparam int SDADC_CTL_DEC_LO  = 4;
	localparam int SDADC_CTL_GAIN_LO = 8;
	localparam int SDADC_CTL_CHOP_LO = 10;
	// Status bits: a new result, and a new result that is settled.
	localparam int SDADC_ST_RESULT  = 0;
	localparam int SDADC_ST_SETTLED = 1;
	localparam logic [11:0] SDADC_CTRL_RST = 12'h000;
	localparam logic [1:0]  SDADC_MASK_RST = 2'h0;
	// Full scale and sample clock division.
	localparam logic signed [31:0] SDADC_FULL_SCALE = 32'sd15625;
	localparam logic [5:0] SDADC_DIV_FAST = 6'd25;
	localparam logic [5:0] SDADC_DIV_SLOW = 6'd50;
	// Results discarded after a restart before one counts as settled.
	localparam logic [1:0] SDADC_SETTLE_RESULTS = 2'd2;
	// Chopper half periods in main clock cycles (period 500 and 1000).
	localparam logic [9:0] SDADC_CHOP_HALF_FAST = 10'd250;
	localparam logic [9:0] SDADC_CHOP_HALF_SLOW = 10'd500;
	localparam logic [1:0] SDADC_CHOP_POS = 2'b00;
	localparam logic [1:0] SDADC_CHOP_NEG = 2'b01;

	// Samples per result for a decimation code; 111 repeats 8000.
	function automatic logic [12:0] sdadc_dec_len(input logic [2:0] code);
		logic [12:0] n;
		n = 13'd125;
		case (code)
			3'd0: n = 13'd125;
			3'd1: n = 13'd250;
			3'd2: n = 13'd500;
			3'd3: n = 13'd1000;
			3'd4: n = 13'd2000;
			3'd5: n = 13'd4000;
			default: n = 13'd8000;
		endcase
		return n;
	endfunction

	// Shift that scales N squared down to 125 squared.
	function automatic logic [3:0] sdadc_dec_shift(input logic [2:0] code);
		logic [3:0] s;
		s = (code == 3'd7) ? 4'd12 : {code, 1'b0};
		return s;
	endfunction
endpackage

// File: design/sdadc_sample_clk.sv
// Purpose: Divides the main clock down to the modulator sample strobe.
// Assumes: Runs only while the modulator is enabled.
// Notes:   Strobe is one cycle wide, once per sample period.
module sdadc_sample_clk
	import sdadc_pkg::*;
(
	// Clock and reset.
	input  wire logic       clk_sys,
	input  wire logic       rst,
	// Control.
	input  wire logic       run,
	input  wire logic       slow_sel,
	// Sample strobe.
	output logic            sample_stb_r
);
	logic [5:0] cnt_r;
	logic [5:0] cnt_nxt;
	logic [5:0] last_w;
	logic       wrap_w;

	// Divide by 25 when the select bit is clear, by 50 when set.
	assign last_w  = (slow_sel ? SDADC_DIV_SLOW : SDADC_DIV_FAST) - 6'd1; // RQ16
	assign wrap_w  = (cnt_r >= last_w);
	assign cnt_nxt = (!run || wrap_w) ? 6'd0 : cnt_r + 6'd1;

	// Counter and strobe; a stopped modulator yields no samples.
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			cnt_r        <= 6'd0;
			sample_stb_r <= 1'b0;
		end
		else
		begin
			cnt_r        <= cnt_nxt;
			sample_stb_r <= run && wrap_w;
		end
	end
endmodule

// File: design/sdadc_comb.sv
// Purpose: Second order comb decimator with scaling and clamping.
// Assumes: One modulator bit per sample strobe, one means plus one.
// Notes:   A clear restarts the integrators and the decimation count.
module sdadc_comb
	import sdadc_pkg::*;
(
	// Clock and reset.
	input  wire logic              clk_sys,
	input  wire logic              rst,
	// Control.
	input  wire logic              clr,
	input  wire logic [2:0]        dec_sel,
	// Modulator samples.
	input  wire logic              sample_stb,
	input  wire logic              mod_bit,
	// Result.
	output logic signed [14:0]     result_r,
	output logic                   result_stb_r
);
	logic signed [31:0] int1_r, int2_r, dly1_r, dly2_r;
	logic [12:0]        cnt_r;
	logic signed [31:0] x_w, comb1_w, comb2_w, scaled_w, clamp_w;
	logic               dump_w;

	// Plus one or minus one per sample; N squared matches full scale at N=125.
	assign x_w      = mod_bit ? 32'sd1 : -32'sd1; // RQ1
	assign dump_w   = sample_stb && (cnt_r >= sdadc_dec_len(dec_sel) - 13'd1); // RQ5 RQ15
	// Two comb stages span 2N samples, so results overlap by N.
	assign comb1_w  = int2_r - dly1_r; // RQ6
	assign comb2_w  = comb1_w - dly2_r;
	assign scaled_w = comb2_w >>> sdadc_dec_shift(dec_sel);
	// Clamp so that ratios at or beyond one give exactly full scale.
	assign clamp_w  = (scaled_w > SDADC_FULL_SCALE) ? SDADC_FULL_SCALE : // RQ2
	                  (scaled_w < -SDADC_FULL_SCALE) ? -SDADC_FULL_SCALE : scaled_w;

	// Integrators run at the sample rate; wrap-around is harmless in a comb.
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			int1_r <= 32'sd0;
			int2_r <= 32'sd0;
			cnt_r  <= 13'd0;
		end
		else if (clr)
		begin
			int1_r <= 32'sd0;
			int2_r <= 32'sd0;
			cnt_r  <= 13'd0;
		end
		else if (sample_stb)
		begin
			int1_r <= int1_r + x_w;
			int2_r <= int2_r + int1_r;
			cnt_r  <= dump_w ? 13'd0 : cnt_r + 13'd1;
		end
	end

	// Comb delays and result once every N samples.
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			dly1_r       <= 32'sd0;
			dly2_r       <= 32'sd0;
			result_r     <= 15'sd0;
			result_stb_r <= 1'b0;
		end
		else if (clr)
		begin
			dly1_r       <= 32'sd0;
			dly2_r       <= 32'sd0;
			result_stb_r <= 1'b0;
		end
		else
		begin
			result_stb_r <= dump_w; // RQ4
			if (dump_w)
			begin
				dly1_r   <= int2_r;
				dly2_r   <= comb1_w;
				result_r <= clamp_w[14:0]; // RQ3
			end
		end
	end
endmodule

// File: verification/sdadc_ctrl_asserts.sv
// Purpose: Port-level checks of the converter register front end.
// Assumes: One wait cycle per access; registered outputs.
// Notes:   Attached by the bind at the foot of this file.
module sdadc_ctrl_asserts
	import sdadc_pkg::*;
(
	// Clock and reset.
	input wire logic        clk_sys,
	input wire logic        rst,
	// Register slave.
	input wire logic [3:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0]  avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	// Interrupt and converter side.
	input wire logic        conversion_irq,
	input wire logic        mod_bit,
	input wire logic        modulator_sample,
	input wire logic        modulator_enable,
	input wire logic        auto_zero_ctl,
	input wire logic [1:0]  input_gain_select,
	input wire logic        chopper_polarity
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////
	// Completed accesses, decoded once for all properties.
	wire acc_done  = (avs_read || avs_write) && !avs_waitrequest;
	wire rd_result = avs_read && !avs_waitrequest && avs_address == SDADC_OFS_RESULT;
	wire rd_status = avs_read && !avs_waitrequest && avs_address == SDADC_OFS_STATUS;
	wire wr_ctrl   = avs_write && !avs_waitrequest && avs_address == SDADC_OFS_CTRL;
	logic [5:0] gap_r;
	logic       seen_r;
	// Cycles since the last strobe; the first strobe after enable is not judged.
	always_ff @(posedge clk_sys or posedge rst)
		if (rst) {seen_r, gap_r} <= 7'h00;
		else if (!modulator_enable) {seen_r, gap_r} <= 7'h00;
		else if (modulator_sample) {seen_r, gap_r} <= 7'h40;
		else if (gap_r != 6'h3f) gap_r <= gap_r + 6'h01;
	////////////////////////////////////////////////////////////////
	property p_wait_one; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
	a_wait_one: assert property (p_wait_one) else $error("access not answered after one wait cycle");
	property p_wait_pulse; !avs_waitrequest |=> avs_waitrequest; endproperty
	a_wait_pulse: assert property (p_wait_pulse) else $error("waitrequest low for more than one cycle");
	property p_wait_cause; $fell(avs_waitrequest) |-> $past(avs_read || avs_write); endproperty
	a_wait_cause: assert property (p_wait_cause) else $error("waitrequest dropped with no request");
	property p_result_rng;
		rd_result |-> $signed(avs_readdata) <= SDADC_FULL_SCALE && $signed(avs_readdata) >= -SDADC_FULL_SCALE
			&& avs_readdata[31:15] == {17{avs_readdata[14]}};
	endproperty
	a_result_rng: assert property (p_result_rng) else $error("result out of range or badly extended");
	property p_status_rsvd; rd_status |-> avs_readdata[31:2] == 30'h0; endproperty
	a_status_rsvd: assert property (p_status_rsvd) else $error("status reads spare bits set");
	property p_sample_en; modulator_sample |-> modulator_enable || $past(modulator_enable); endproperty
	a_sample_en: assert property (p_sample_en) else $error("sample strobe with modulator off");
	property p_sample_gap; modulator_sample && modulator_enable && seen_r |-> gap_r == 6'd24 || gap_r == 6'd49; endproperty
	a_sample_gap: assert property (p_sample_gap) else $error("sample strobe spacing not 25 or 50");
	property p_ctrl_cause;
		$changed({modulator_enable, auto_zero_ctl, input_gain_select}) |-> $past(wr_ctrl) || $past(wr_ctrl, 2);
	endproperty
	a_ctrl_cause: assert property (p_ctrl_cause) else $error("control output moved without a write");
	property p_irq_fall; $fell(conversion_irq) |-> $past(acc_done) || $past(acc_done, 2); endproperty
	a_irq_fall: assert property (p_irq_fall) else $error("interrupt dropped without an access");
	c_result: cover property (rd_result);
	c_irq: cover property ($rose(conversion_irq));
	c_az: cover property ($fell(auto_zero_ctl));
endmodule

bind sdadc_ctrl sdadc_ctrl_asserts u_sdadc_ctrl_asserts (
	.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .conversion_irq(conversion_irq), .mod_bit(mod_bit),
	.modulator_sample(modulator_sample), .modulator_enable(modulator_enable), .auto_zero_ctl(auto_zero_ctl),
	.input_gain_select(input_gain_select), .chopper_polarity(chopper_polarity)
);

// File: verification/sdadc_mod_model.sv
// Purpose: Modulator bit source on the far side of the converter logic.
// Assumes: Pattern 0 gives all minus one, 1 all plus one, 2 alternates.
// Notes:   Shorted inputs alternate, as a zero differential input would.
module sdadc_mod_model
(
	// Clock and reset.
	input  wire logic       clk_sys,
	input  wire logic       rst,
	// Converter side.
	input  wire logic       modulator_sample,
	input  wire logic       auto_zero_ctl,
	input  wire logic [1:0] pattern,
	output logic            mod_bit
);
	timeunit 1ns;
	timeprecision 1ps;
	logic tog_r;
	// The bit moves only after a strobe has taken it, so it is valid in the strobe cycle.
	always_ff @(posedge clk_sys or posedge rst)
		if (rst) tog_r <= 1'b0;
		else if (modulator_sample) tog_r <= ~tog_r;
	// With the inputs shorted the stream averages to zero.
	assign mod_bit = (auto_zero_ctl || pattern == 2'h2) ? tog_r : pattern[0];
endmodule

// File: verification/tb.sv
// Purpose: Self-checking bench for the converter register front end.
// Assumes: Decimation 125 at the fast rate gives a result every 3125 clocks.
// Notes:   Expected codes come from full scale, never from the design.
module tb import sdadc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_sys = 1'b0;
	logic        rst = 1'b1;
	logic [3:0]  avs_address = 4'h0;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0]  avs_byteenable = 4'hf;
	logic [1:0]  pat = 2'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest, conversion_irq, mod_bit, modulator_sample;
	logic        modulator_enable, auto_zero_ctl, chopper_polarity;
	logic [1:0]  input_gain_select;
	int          n_errors = 0;
	int          checks_done = 0;
	int          cyc = 0;
	////////////////////////////////////////////////////////////////
	// Free-running clock and a cycle count used for spacing checks.
	always #5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) cyc <= cyc + 1;
	sdadc_ctrl u_sdadc_ctrl (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .conversion_irq(conversion_irq),
		.mod_bit(mod_bit), .modulator_sample(modulator_sample), .modulator_enable(modulator_enable),
		.auto_zero_ctl(auto_zero_ctl), .input_gain_select(input_gain_select), .chopper_polarity(chopper_polarity));
	sdadc_mod_model u_sdadc_mod_model (.clk_sys(clk_sys), .rst(rst), .modulator_sample(modulator_sample),
		.auto_zero_ctl(auto_zero_ctl), .pattern(pat), .mod_bit(mod_bit));
	////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// One access; an idle edge follows so the strobe is never set twice at one edge.
	// The wait has no limit of its own; only the watchdog ends a hung access.
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		@(posedge clk_sys);
		while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] q);
		bus(1'b0, a, 32'h0, q);
	endtask
	task automatic wait_irq(output int t);
		repeat (2) @(posedge clk_sys);
		while (conversion_irq !== 1'b1) @(posedge clk_sys);
		t = cyc;
	endtask
	// Restart, then take three results: only the third may count as settled.
	task automatic run3(input logic [31:0] ctl, input int g, output logic [31:0] q);
		int t0, t1;
		wr(SDADC_OFS_CTRL, 32'h0);
		wr(SDADC_OFS_CTRL, ctl);
		rd(SDADC_OFS_STATUS, q);
		for (int i = 1; i <= 3; i++)
		begin
			t0 = t1;
			wait_irq(t1);
			rd(SDADC_OFS_STATUS, q);
			chk("status", q, (i == 3) ? 32'h3 : 32'h1);
		end
		chk("result spacing", 32'(t1 - t0), 32'(g));
		rd(SDADC_OFS_RESULT, q);
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_rst();
		logic [31:0] q;
		chk("idle wait", avs_waitrequest, 32'h1);
		for (int a = 0; a < 16; a += 2)
		begin
			rd(4'(a), q);
			chk("reset read", q, 32'h0);
		end
		wr(4'h2, 32'hfff);
		rd(SDADC_OFS_CTRL, q);
		chk("unmapped write", q, 32'h0);
	endtask
	task automatic t_ctl();
		int t0;
		logic p;
		for (int g = 0; g < 4; g++)
		begin
			wr(SDADC_OFS_CTRL, 32'(g) << 8);
			@(posedge clk_sys); // The pin register follows the write by one edge.
			chk("gain", input_gain_select, 32'(g));
		end
		for (int c = 0; c < 4; c++)
		begin
			wr(SDADC_OFS_CTRL, 32'(c) << 10);
			@(posedge clk_sys); // Polarity is registered one edge after the write.
			if (c < 2) chk("chopper", chopper_polarity, 32'(c));
			else
			begin
				p = chopper_polarity;
				while (chopper_polarity === p && cyc < 90000) @(posedge clk_sys);
				t0 = cyc;
				p = chopper_polarity;
				while (chopper_polarity === p && cyc < 90000) @(posedge clk_sys);
				chk("chop half period", 32'(cyc - t0), 32'(250 * (c - 1)));
			end
		end
	endtask
	task automatic t_neg();
		logic [31:0] q;
		pat <= 2'h0;
		wr(SDADC_OFS_CTRL, 32'h3);
		repeat (3300) @(posedge clk_sys);
		chk("masked irq", conversion_irq, 32'h0);
		wr(SDADC_OFS_MASK, 32'h1);
		repeat (2) @(posedge clk_sys);
		chk("pending irq", conversion_irq, 32'h1);
		rd(SDADC_OFS_STATUS, q);
		chk("first status", q, 32'h1);
		repeat (2) @(posedge clk_sys);
		chk("cleared irq", conversion_irq, 32'h0);
		run3(32'h3, 3125, q);
		chk("negative full scale", q, 32'hffffc2f7);
	endtask
	task automatic t_az();
		logic [31:0] q;
		pat <= 2'h1;
		run3(32'h7, 3125, q);
		chk("shorted", auto_zero_ctl, 32'h1);
		chk("offset small", 32'($signed(q) <= 125 && $signed(q) >= -125), 32'h1);
		run3(32'h3, 3125, q);
		chk("inputs back", auto_zero_ctl, 32'h0);
		chk("positive full scale", q, 32'h3d09);
	endtask
	task automatic t_rate();
		logic [31:0] q;
		int t0;
		for (int s = 0; s < 2; s++)
		begin
			wr(SDADC_OFS_CTRL, 32'h0);
			wr(SDADC_OFS_CTRL, 32'h1 | (32'(s) << 3));
			while (modulator_sample !== 1'b1 && cyc < 90000) @(posedge clk_sys);
			t0 = cyc;
			@(posedge clk_sys);
			while (modulator_sample !== 1'b1 && cyc < 90000) @(posedge clk_sys);
			chk("sample period", 32'(cyc - t0), 32'(25 * (s + 1)));
			chk("modulator on", modulator_enable, 32'h1);
		end
		run3(32'h13, 6250, q);
		chk("decimated full scale", q, 32'h3d09);
	endtask
	////////////////////////////////////////////////////////////////
	task automatic summarize();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Main sequence after a four-cycle reset.
	initial
	begin
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		t_rst();
		t_ctl();
		t_neg();
		t_az();
		t_rate();
		summarize();
	end
	// The tests need about 52000 cycles; this cuts a hang at 100000.
	initial
	begin
		#1000000;
		n_errors++;
		summarize();
	end
endmodule
